// *** hpc_defs.vh ***
// How it works
// - One high and low limit for all cells
// - Channels up to highest number are active
// - Two mask registers drop low-limit checks
// - Active cell above high limit sets fault
// - Active unmasked cell below low limit faults
// - Two-bit cell mode, started by start bit
// - Self test blanks or freezes ADC results
// - Cell start latches limits, mode, masks
// - Cell protector keeps running through sleep
// - Running bit plus high and low faults
// - Balance done stops balancing, no fault
// - One hot and cold limit for pins
// - Pin active only when set temp input
// - Ratio below hot limit sets hot fault
// - Ratio above cold limit sets cold fault
// - Reference off flags every hot and cold
// - Two-bit temp mode, started by start bit
// - Round robin cycle time is fixed
// - Temp start latches limits, mode, pin setup
// - Temp protector keeps running through sleep
// - Temp running bit plus hot, cold faults
// - Balance hot pauses balancing, no fault
`ifndef HPC_DEFS_VH
`define HPC_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define HPC_CLK_NS 50
`define HPC_DWELL_NS 1000
`define HPC_SETTLE_NS 500
`define HPC_CYC(ns) (((ns) + `HPC_CLK_NS - 1) / `HPC_CLK_NS)

// ****************************************
// Modes and codes
// ****************************************
`define HPC_MODE_STOP 2'h0
`define HPC_MODE_RR 2'h1
`define HPC_MODE_ONE 2'h2
`define HPC_MODE_BUILT_IN_SELF_TEST 2'h3
`define HPC_PIN_TEMP_IN 3'h2
`define HPC_ADC_BLANK 16'h8000

// ****************************************
// Register offsets
// ****************************************
`define HPC_A_HIGH 8'h00
`define HPC_A_LOW 8'h04
`define HPC_A_BDONE 8'h08
`define HPC_A_TOPCH 8'h0C
`define HPC_A_MASK_LO 8'h10
`define HPC_A_MASK_HI 8'h14
`define HPC_A_CCTRL 8'h18
`define HPC_A_TLIM 8'h1C
`define HPC_A_BHOT 8'h20
`define HPC_A_PINCFG 8'h24
`define HPC_A_TCTRL 8'h28
`define HPC_A_STAT 8'h2C
`define HPC_A_HF_LO 8'h30
`define HPC_A_HF_HI 8'h34
`define HPC_A_LF_LO 8'h38
`define HPC_A_LF_HI 8'h3C
`define HPC_A_HOTF 8'h40
`define HPC_A_COLDF 8'h44
`define HPC_A_ADC 8'h48

// ****************************************
// Fields and reset values
// ****************************************
`define HPC_F_MODE 1:0
`define HPC_F_GO 2
`define HPC_F_HOT 4:0
`define HPC_F_COLD 7:5
`define HPC_S_CRUN 0
`define HPC_S_TRUN 1
`define HPC_S_BUILT_IN_SELF_TEST 2
`define HPC_RST_LIMIT 8'h00
`define HPC_RST_TOPCH 4'hF
`define HPC_RST_PINCFG 24'h000000

`endif

// *** hpc_scan.v ***
`timescale 1ns/1ps
// Channel sequencer with a fixed dwell per slot
module hpc_scan #(
  parameter N = 16,
  parameter IW = 4,
  parameter DWELL = 20
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  input wire fix_i,
  input wire [IW-1:0] fix_idx_i,
  output reg [IW-1:0] idx_o,
  output reg eval_o,
  output reg wrap_o
);

  reg [15:0] cnt_q;
  wire last = (cnt_q == DWELL[15:0] - 16'h0001);

  // Every slot gets a dwell, active or not, so the cycle time is fixed
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 16'h0000;
      idx_o <= {IW{1'b0}};
      eval_o <= 1'b0;
      wrap_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q <= 16'h0000;
      idx_o <= fix_i ? fix_idx_i : {IW{1'b0}};
      eval_o <= 1'b0;
      wrap_o <= 1'b0;
    end else begin
      eval_o <= last;
      wrap_o <= last & (idx_o == N[IW-1:0] - 1'b1) & ~fix_i;
      if (last) begin
        cnt_q <= 16'h0000;
        if (fix_i)
          idx_o <= fix_idx_i;
        else if (idx_o == N[IW-1:0] - 1'b1)
          idx_o <= {IW{1'b0}};
        else
          idx_o <= idx_o + 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

endmodule

// *** hpc_top.v ***
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "hpc_defs.vh"
// Hardware protector control: cell and temperature protectors
module hpc_top #(
  parameter NCELL = 16,
  parameter NPIN = 8,
  parameter [1:0] MODE_STOP = `HPC_MODE_STOP,
  parameter [1:0] MODE_RR = `HPC_MODE_RR,
  parameter [1:0] MODE_ONE = `HPC_MODE_ONE,
  parameter [1:0] MODE_BUILT_IN_SELF_TEST = `HPC_MODE_BUILT_IN_SELF_TEST,
  parameter DWELL_NS = `HPC_DWELL_NS,
  parameter SETTLE_NS = `HPC_SETTLE_NS
) (
  input wire REF_CLK_I,
  input wire RESET_N_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  input wire [15:0] CELL_HIGH_CMP_I,
  input wire [15:0] CELL_LOW_CMP_I,
  input wire [15:0] BALANCE_DONE_CMP_I,
  input wire [7:0] HOT_CMP_I,
  input wire [7:0] COLD_CMP_I,
  input wire [7:0] BALANCE_HOT_CMP_I,
  input wire THERM_REF_EN_I,
  input wire SHUTDOWN_I,
  input wire ADC_START_I,
  input wire ADC_RUNNING_I,
  input wire ADC_VALID_I,
  input wire [15:0] ADC_DATA_I,
  output reg [7:0] CELL_HIGH_LIMIT_O,
  output reg [7:0] CELL_LOW_LIMIT_O,
  output reg [7:0] BALANCE_DONE_LIMIT_O,
  output reg [4:0] HOT_LIMIT_O,
  output reg [2:0] COLD_LIMIT_O,
  output reg [7:0] BALANCE_HOT_LIMIT_O,
  output wire [3:0] CELL_SCAN_CH_O,
  output wire [2:0] TEMP_SCAN_CH_O,
  output reg [15:0] BAL_STOP_O,
  output reg [7:0] BAL_PAUSE_O,
  output reg [15:0] ADC_RESULT_O,
  output reg CELL_RUN_O,
  output reg TEMP_RUN_O
);

  // ****************************************
  // Constants
  // ****************************************
  localparam DWELL = `HPC_CYC(DWELL_NS);
  localparam SETTLE = `HPC_CYC(SETTLE_NS);
  localparam [15:0] SETTLE_CNT = SETTLE[15:0];

  // ****************************************
  // Functions
  // ****************************************
  // Channels at or below the highest number count as active
  function [15:0] cell_active;
    input [3:0] top;
    integer i;
    begin
      cell_active = 16'h0000;
      for (i = 0; i < 16; i = i + 1)
        cell_active[i] = (i <= top);
    end
  endfunction

  // Pins set as ADC plus temperature input count as active
  function [7:0] pin_active;
    input [23:0] cfg;
    integer j;
    begin
      pin_active = 8'h00;
      for (j = 0; j < 8; j = j + 1)
        pin_active[j] = (cfg[3*j +: 3] == `HPC_PIN_TEMP_IN);
    end
  endfunction

  // ****************************************
  // Software settings
  // ****************************************
  reg [7:0] high_limit_q;
  reg [7:0] low_limit_q;
  reg [7:0] bdone_limit_q;
  reg [3:0] top_ch_q;
  reg [7:0] mask_lo_q;
  reg [7:0] mask_hi_q;
  reg [1:0] cmode_sel_q;
  reg [7:0] tlim_q;
  reg [7:0] bhot_q;
  reg [23:0] pincfg_q;
  reg [1:0] tmode_sel_q;
  // Settings in force, captured at start
  reg [3:0] cur_top_q;
  reg [15:0] cur_mask_q;
  reg [1:0] cur_cmode_q;
  reg [23:0] cur_pincfg_q;
  reg [1:0] cur_tmode_q;
  // Status and faults
  reg [15:0] high_flt_q;
  reg [15:0] low_flt_q;
  reg [7:0] hot_flt_q;
  reg [7:0] cold_flt_q;
  reg [15:0] settle_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire acc = PSEL_I & PENABLE_I;
  wire fin = acc & PREADY_O;
  wire wr = fin & PWRITE_I;
  wire cgo = wr & (PADDR_I == `HPC_A_CCTRL) & PWDATA_I[`HPC_F_GO];
  wire tgo = wr & (PADDR_I == `HPC_A_TCTRL) & PWDATA_I[`HPC_F_GO];
  wire [1:0] cmode_new = PWDATA_I[`HPC_F_MODE];
  wire [1:0] tmode_new = PWDATA_I[`HPC_F_MODE];
  wire cell_built_in_self_test = CELL_RUN_O & (cur_cmode_q == MODE_BUILT_IN_SELF_TEST);
  reg [31:0] rdata;
  reg hit;
  // Read mux and address check
  always @* begin
    rdata = 32'h00000000;
    hit = 1'b1;
    case (PADDR_I)
      `HPC_A_HIGH: rdata[7:0] = high_limit_q;
      `HPC_A_LOW: rdata[7:0] = low_limit_q;
      `HPC_A_BDONE: rdata[7:0] = bdone_limit_q;
      `HPC_A_TOPCH: rdata[3:0] = top_ch_q;
      `HPC_A_MASK_LO: rdata[7:0] = mask_lo_q;
      `HPC_A_MASK_HI: rdata[7:0] = mask_hi_q;
      `HPC_A_CCTRL: rdata[`HPC_F_MODE] = cmode_sel_q;
      `HPC_A_TLIM: rdata[7:0] = tlim_q;
      `HPC_A_BHOT: rdata[7:0] = bhot_q;
      `HPC_A_PINCFG: rdata[23:0] = pincfg_q;
      `HPC_A_TCTRL: rdata[`HPC_F_MODE] = tmode_sel_q;
      `HPC_A_STAT: begin
        rdata[`HPC_S_CRUN] = CELL_RUN_O;
        rdata[`HPC_S_TRUN] = TEMP_RUN_O;
        rdata[`HPC_S_BUILT_IN_SELF_TEST] = cell_built_in_self_test;
      end
      `HPC_A_HF_LO: rdata[7:0] = high_flt_q[7:0];
      `HPC_A_HF_HI: rdata[7:0] = high_flt_q[15:8];
      `HPC_A_LF_LO: rdata[7:0] = low_flt_q[7:0];
      `HPC_A_LF_HI: rdata[7:0] = low_flt_q[15:8];
      `HPC_A_HOTF: rdata[7:0] = hot_flt_q;
      `HPC_A_COLDF: rdata[7:0] = cold_flt_q;
      `HPC_A_ADC: rdata[15:0] = ADC_RESULT_O;
      default: hit = 1'b0;
    endcase
  end

  // One wait state, then the answer with data or error
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= acc & ~PREADY_O;
      PSLVERR_O <= acc & ~PREADY_O & ~hit;
      if (acc & ~PREADY_O & ~PWRITE_I)
        PRDATA_O <= rdata;
      else if (fin)
        PRDATA_O <= 32'h00000000;
    end
  end

  // ****************************************
  // Setting registers
  // ****************************************
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      high_limit_q <= `HPC_RST_LIMIT;
      low_limit_q <= `HPC_RST_LIMIT;
      bdone_limit_q <= `HPC_RST_LIMIT;
      top_ch_q <= `HPC_RST_TOPCH;
      mask_lo_q <= `HPC_RST_LIMIT;
      mask_hi_q <= `HPC_RST_LIMIT;
      cmode_sel_q <= `HPC_MODE_STOP;
      tlim_q <= `HPC_RST_LIMIT;
      bhot_q <= `HPC_RST_LIMIT;
      pincfg_q <= `HPC_RST_PINCFG;
      tmode_sel_q <= `HPC_MODE_STOP;
    end else if (wr) begin
      case (PADDR_I)
        `HPC_A_HIGH: high_limit_q <= PWDATA_I[7:0];
        `HPC_A_LOW: low_limit_q <= PWDATA_I[7:0];
        `HPC_A_BDONE: bdone_limit_q <= PWDATA_I[7:0];
        `HPC_A_TOPCH: top_ch_q <= PWDATA_I[3:0];
        `HPC_A_MASK_LO: mask_lo_q <= PWDATA_I[7:0];
        `HPC_A_MASK_HI: mask_hi_q <= PWDATA_I[7:0];
        `HPC_A_CCTRL: cmode_sel_q <= cmode_new;
        `HPC_A_TLIM: tlim_q <= PWDATA_I[7:0];
        `HPC_A_BHOT: bhot_q <= PWDATA_I[7:0];
        `HPC_A_PINCFG: pincfg_q <= PWDATA_I[23:0];
        `HPC_A_TCTRL: tmode_sel_q <= tmode_new;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Cell protector control
  // ****************************************
  wire cell_one = cur_cmode_q == MODE_ONE;
  wire [3:0] cidx;
  wire ceval;
  wire cwrap;
  // Cell sequencer; single mode holds the highest active channel
  hpc_scan #(.N(NCELL), .IW(4), .DWELL(DWELL)) u_cell_scan (
    .clk_i(REF_CLK_I), .rst_n_i(RESET_N_I), .run_i(CELL_RUN_O), .fix_i(cell_one),
    .fix_idx_i(cur_top_q), .idx_o(cidx), .eval_o(ceval), .wrap_o(cwrap)
  );
  assign CELL_SCAN_CH_O = cidx;

  // Start latches settings; sleep does not stop it, shutdown does
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      CELL_RUN_O <= 1'b0;
      cur_cmode_q <= `HPC_MODE_STOP;
      cur_top_q <= `HPC_RST_TOPCH;
      cur_mask_q <= 16'h0000;
      CELL_HIGH_LIMIT_O <= `HPC_RST_LIMIT;
      CELL_LOW_LIMIT_O <= `HPC_RST_LIMIT;
      BALANCE_DONE_LIMIT_O <= `HPC_RST_LIMIT;
    end else if (SHUTDOWN_I) begin
      CELL_RUN_O <= 1'b0;
    end else if (cgo) begin
      CELL_RUN_O <= (cmode_new != MODE_STOP);
      cur_cmode_q <= cmode_new;
      cur_top_q <= top_ch_q;
      cur_mask_q <= {mask_hi_q, mask_lo_q};
      CELL_HIGH_LIMIT_O <= high_limit_q;
      CELL_LOW_LIMIT_O <= low_limit_q;
      BALANCE_DONE_LIMIT_O <= bdone_limit_q;
    end else if (cell_built_in_self_test & cwrap) begin
      CELL_RUN_O <= 1'b0;
    end
  end

  // ****************************************
  // Cell faults and balance stop
  // ****************************************
  wire [15:0] cact = cell_active(cur_top_q);
  wire [15:0] csel = (ceval & ~cell_built_in_self_test) ? (16'h0001 << cidx) : 16'h0000;
  wire [15:0] hset = csel & cact & CELL_HIGH_CMP_I;
  wire [15:0] lset = csel & cact & ~cur_mask_q & CELL_LOW_CMP_I;
  wire hf_lo_clr = wr & (PADDR_I == `HPC_A_HF_LO);
  wire hf_hi_clr = wr & (PADDR_I == `HPC_A_HF_HI);
  wire lf_lo_clr = wr & (PADDR_I == `HPC_A_LF_LO);
  wire lf_hi_clr = wr & (PADDR_I == `HPC_A_LF_HI);
  wire [15:0] hclr = {hf_hi_clr ? PWDATA_I[7:0] : 8'h00, hf_lo_clr ? PWDATA_I[7:0] : 8'h00};
  wire [15:0] lclr = {lf_hi_clr ? PWDATA_I[7:0] : 8'h00, lf_lo_clr ? PWDATA_I[7:0] : 8'h00};

  // Sticky flags, write one to clear, a new event wins
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      high_flt_q <= 16'h0000;
      low_flt_q <= 16'h0000;
      BAL_STOP_O <= 16'h0000;
    end else begin
      high_flt_q <= (high_flt_q & ~hclr) | hset;
      low_flt_q <= (low_flt_q & ~lclr) | lset;
      if (cgo)
        BAL_STOP_O <= 16'h0000;
      else
        BAL_STOP_O <= BAL_STOP_O | (csel & cact & BALANCE_DONE_CMP_I);
    end
  end

  // ****************************************
  // Temperature protector control
  // ****************************************
  wire temp_built_in_self_test = TEMP_RUN_O & (cur_tmode_q == MODE_BUILT_IN_SELF_TEST);
  wire temp_one = cur_tmode_q == MODE_ONE;
  wire [2:0] tidx;
  wire teval;
  wire twrap;
  // Pin sequencer; every slot dwells, so the cycle time is fixed
  hpc_scan #(.N(NPIN), .IW(3), .DWELL(DWELL)) u_temp_scan (
    .clk_i(REF_CLK_I), .rst_n_i(RESET_N_I), .run_i(TEMP_RUN_O), .fix_i(temp_one),
    .fix_idx_i(3'h0), .idx_o(tidx), .eval_o(teval), .wrap_o(twrap)
  );
  assign TEMP_SCAN_CH_O = tidx;

  // Start latches limits, pin setup and mode
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TEMP_RUN_O <= 1'b0;
      cur_tmode_q <= `HPC_MODE_STOP;
      cur_pincfg_q <= `HPC_RST_PINCFG;
      HOT_LIMIT_O <= 5'h00;
      COLD_LIMIT_O <= 3'h0;
      BALANCE_HOT_LIMIT_O <= `HPC_RST_LIMIT;
    end else if (SHUTDOWN_I) begin
      TEMP_RUN_O <= 1'b0;
    end else if (tgo) begin
      TEMP_RUN_O <= (tmode_new != MODE_STOP);
      cur_tmode_q <= tmode_new;
      cur_pincfg_q <= pincfg_q;
      HOT_LIMIT_O <= tlim_q[`HPC_F_HOT];
      COLD_LIMIT_O <= tlim_q[`HPC_F_COLD];
      BALANCE_HOT_LIMIT_O <= bhot_q;
    end else if (temp_built_in_self_test & twrap) begin
      TEMP_RUN_O <= 1'b0;
    end
  end

  // ****************************************
  // Temperature faults and balance pause
  // ****************************************
  wire [7:0] tact = pin_active(cur_pincfg_q);
  wire tchk = teval & ~temp_built_in_self_test;
  wire [7:0] tsel = tchk ? (8'h01 << tidx) : 8'h00;
  wire ref_bad = tchk & ~THERM_REF_EN_I;
  wire [7:0] hotset = ref_bad ? 8'hFF : (tsel & tact & HOT_CMP_I);
  wire [7:0] coldset = ref_bad ? 8'hFF : (tsel & tact & COLD_CMP_I);
  wire [7:0] hotclr = (wr & (PADDR_I == `HPC_A_HOTF)) ? PWDATA_I[7:0] : 8'h00;
  wire [7:0] coldclr = (wr & (PADDR_I == `HPC_A_COLDF)) ? PWDATA_I[7:0] : 8'h00;

  // Sticky flags; balance pause follows the last look at each pin
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hot_flt_q <= 8'h00;
      cold_flt_q <= 8'h00;
      BAL_PAUSE_O <= 8'h00;
    end else begin
      hot_flt_q <= (hot_flt_q & ~hotclr) | hotset;
      cold_flt_q <= (cold_flt_q & ~coldclr) | coldset;
      if (!TEMP_RUN_O)
        BAL_PAUSE_O <= 8'h00;
      else if (tchk)
        BAL_PAUSE_O[tidx] <= tact[tidx] & BALANCE_HOT_CMP_I[tidx];
    end
  end

  // ****************************************
  // ADC result interlock
  // ****************************************
  wire adc_block = cell_built_in_self_test | (settle_q != 16'h0000);

  // Settling delay after self test, then results update again
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      settle_q <= 16'h0000;
      ADC_RESULT_O <= 16'h0000;
    end else begin
      if (cell_built_in_self_test)
        settle_q <= SETTLE_CNT;
      else if (settle_q != 16'h0000)
        settle_q <= settle_q - 16'h0001;
      if (cell_built_in_self_test & ADC_START_I & ~ADC_RUNNING_I)
        ADC_RESULT_O <= `HPC_ADC_BLANK;
      else if (ADC_VALID_I & ~adc_block)
        ADC_RESULT_O <= ADC_DATA_I;
    end
  end

endmodule

// *** hpc_chk.sv ***
`timescale 1ns/1ps
`include "hpc_defs.vh"
// Timing checks on the protector control top ports
module hpc_chk (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  input wire logic SHUTDOWN_I,
  input wire logic ADC_START_I,
  input wire logic ADC_RUNNING_I,
  input wire logic [15:0] ADC_RESULT_O,
  input wire logic [7:0] CELL_HIGH_LIMIT_O,
  input wire logic CELL_RUN_O,
  input wire logic TEMP_RUN_O
);
  // ********
  // Helper logic
  // ********
  localparam int SWEEP_MAX = 400;
  wire logic wr_done;
  wire logic cell_go;
  wire logic temp_go;
  logic cbist_q;
  logic tbist_q;
  // Completed start writes to the control registers
  assign wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PWDATA_I[`HPC_F_GO];
  assign cell_go = wr_done && PADDR_I == `HPC_A_CCTRL;
  assign temp_go = wr_done && PADDR_I == `HPC_A_TCTRL;
  // Remember whether the last start asked for self test
  always @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cbist_q <= 1'b0;
      tbist_q <= 1'b0;
    end else begin
      if (cell_go)
        cbist_q <= PWDATA_I[1:0] == `HPC_MODE_BUILT_IN_SELF_TEST;
      if (temp_go)
        tbist_q <= PWDATA_I[1:0] == `HPC_MODE_BUILT_IN_SELF_TEST;
    end
  end
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // ********
  // Properties
  // ********
  sequence s_setup;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence s_sweep;
    CELL_RUN_O ##[1:SWEEP_MAX] !CELL_RUN_O;
  endsequence
  property p_answer;
    s_setup |-> ##[1:3] PREADY_O;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no ready after setup");
  property p_cell_start;
    cell_go && PWDATA_I[1:0] != `HPC_MODE_STOP && !SHUTDOWN_I |-> ##[1:2] CELL_RUN_O;
  endproperty
  a_cell_start: assert property (p_cell_start)
    else $error("cell run not set by start");
  property p_cell_stop;
    cell_go && PWDATA_I[1:0] == `HPC_MODE_STOP |-> ##[1:2] !CELL_RUN_O;
  endproperty
  a_cell_stop: assert property (p_cell_stop)
    else $error("cell run not cleared by stop");
  property p_cell_keep;
    CELL_RUN_O && !cbist_q && !SHUTDOWN_I && !cell_go && !$past(cell_go) |=> CELL_RUN_O;
  endproperty
  a_cell_keep: assert property (p_cell_keep)
    else $error("cell protector stopped by itself");
  property p_cell_latch;
    !$stable(CELL_HIGH_LIMIT_O) |-> $past(cell_go) || $past(cell_go, 2);
  endproperty
  a_cell_latch: assert property (p_cell_latch)
    else $error("cell limit changed without start");
  property p_temp_keep;
    TEMP_RUN_O && !tbist_q && !SHUTDOWN_I && !temp_go && !$past(temp_go) |=> TEMP_RUN_O;
  endproperty
  a_temp_keep: assert property (p_temp_keep)
    else $error("temp protector stopped by itself");
  property p_shut;
    $rose(SHUTDOWN_I) |-> ##[1:2] !CELL_RUN_O && !TEMP_RUN_O;
  endproperty
  a_shut: assert property (p_shut)
    else $error("protectors still run in shutdown");
  property p_built_in_self_test_end;
    cell_go && PWDATA_I[1:0] == `HPC_MODE_BUILT_IN_SELF_TEST && !SHUTDOWN_I |-> ##[1:2] s_sweep;
  endproperty
  a_built_in_self_test_end: assert property (p_built_in_self_test_end)
    else $error("self test sweep did not end");
  property p_adc_blank;
    cbist_q && CELL_RUN_O && ADC_START_I && !ADC_RUNNING_I |-> ##[1:2]
      ADC_RESULT_O == `HPC_ADC_BLANK;
  endproperty
  a_adc_blank: assert property (p_adc_blank)
    else $error("adc result not blanked in self test");
endmodule

// *** tb_hw_protector_control.sv ***
`timescale 1ns/1ps
`include "hpc_defs.vh"
// Self-checking bench for the protector control block
module tb_hw_protector_control;
  // ********
  // Signals
  // ********
  logic clk, rst_n, psel, pen, pwr, tref, shut, astart, arun, avalid;
  logic [7:0] paddr, hot, cold, bhot;
  logic [31:0] pwdata, r, lim;
  logic [15:0] chigh, clow, bdone, adata;
  logic [32:0] q[$];
  logic [31:0] seed = 32'h9F953B4E;
  wire [31:0] prdata;
  wire pready, perr, crun, trun;
  wire [7:0] hl, ll, bl, bhl, pause;
  wire [4:0] hotl;
  wire [2:0] coldl, tch;
  wire [3:0] cch;
  wire [15:0] stop, ares;
  int err_total, compares;
  hpc_top #(.DWELL_NS(100), .SETTLE_NS(100)) hpc_top_i (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(perr), .CELL_HIGH_CMP_I(chigh), .CELL_LOW_CMP_I(clow),
    .BALANCE_DONE_CMP_I(bdone), .HOT_CMP_I(hot), .COLD_CMP_I(cold),
    .BALANCE_HOT_CMP_I(bhot), .THERM_REF_EN_I(tref), .SHUTDOWN_I(shut),
    .ADC_START_I(astart), .ADC_RUNNING_I(arun), .ADC_VALID_I(avalid), .ADC_DATA_I(adata),
    .CELL_HIGH_LIMIT_O(hl), .CELL_LOW_LIMIT_O(ll), .BALANCE_DONE_LIMIT_O(bl),
    .HOT_LIMIT_O(hotl), .COLD_LIMIT_O(coldl), .BALANCE_HOT_LIMIT_O(bhl),
    .CELL_SCAN_CH_O(cch), .TEMP_SCAN_CH_O(tch), .BAL_STOP_O(stop), .BAL_PAUSE_O(pause),
    .ADC_RESULT_O(ares), .CELL_RUN_O(crun), .TEMP_RUN_O(trun));
  // ********
  // Tasks
  // ********
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp_val(input string nm, input logic [32:0] e, input logic [32:0] s);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_rd(input logic [32:0] e);
    cmp_val("read word", e, {perr, prdata});
  endtask
  // One bus transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    q.push_back({er, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic adc(input logic [15:0] d);
    adata <= d;
    avalid <= 1'b1;
    @(posedge clk);
    avalid <= 1'b0;
    cyc(3);
  endtask
  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ********
  // Clock, monitor, watchdog
  // ********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Read results taken at the ready edge against the oldest note
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr)
      cmp_rd(q.pop_front());
  end
  initial begin
    cyc(5000);
    err_total++;
    end_of_test();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    {psel, pen, pwr, tref, shut, astart, arun, avalid} = 8'h00;
    {paddr, hot, cold, bhot} = 32'h0;
    {chigh, clow, bdone, adata} = 64'h0;
    pwdata = 32'h0;
    rst_n = 1'b0;
    cyc(6);
    rst_n <= 1'b1;
    rd(`HPC_A_TOPCH, 32'hF);
    rd(`HPC_A_STAT, 32'h0);
    rd(8'h80, 32'h0, 1'b1);
    $display("test reset done");
    r = rnd();
    lim = rnd() & 32'hFF;
    chigh <= r[15:0];
    clow <= r[31:16];
    bdone <= 16'h0001;
    wr(`HPC_A_HIGH, lim);
    wr(`HPC_A_LOW, 32'h33);
    wr(`HPC_A_BDONE, 32'h44);
    wr(`HPC_A_TOPCH, 32'h3);
    wr(`HPC_A_MASK_LO, 32'h02);
    wr(`HPC_A_CCTRL, 32'h5);
    cyc(2);
    cmp_val("high limit", lim, hl);
    cmp_val("low limit", 32'h33, ll);
    cmp_val("done limit", 32'h44, bl);
    cmp_val("cell run", 32'h1, crun);
    wr(`HPC_A_HIGH, ~lim & 32'hFF);
    cyc(80);
    cmp_val("held limit", lim, hl);
    cmp_val("cell still run", 32'h1, crun);
    rd(`HPC_A_HF_LO, r & 32'hF);
    rd(`HPC_A_HF_HI, 32'h0);
    rd(`HPC_A_LF_LO, (r >> 16) & 32'hD);
    rd(`HPC_A_LF_HI, 32'h0);
    rd(`HPC_A_STAT, 32'h1);
    cmp_val("balance stop", 32'h1, stop[0]);
    $display("test cell scan done");
    wr(`HPC_A_CCTRL, 32'h4);
    cyc(2);
    cmp_val("cell stopped", 32'h0, crun);
    wr(`HPC_A_HF_LO, 32'hFFFF);
    rd(`HPC_A_HF_LO, 32'h0);
    r = rnd();
    adc(r[15:0]);
    cmp_val("adc result", r[15:0], ares);
    wr(`HPC_A_CCTRL, 32'h7);
    cyc(2);
    rd(`HPC_A_STAT, 32'h5);
    astart <= 1'b1;
    @(posedge clk);
    astart <= 1'b0;
    cyc(2);
    cmp_val("adc blank", `HPC_ADC_BLANK, ares);
    adc(~r[15:0]);
    cmp_val("adc frozen", `HPC_ADC_BLANK, ares);
    cyc(80);
    cmp_val("self test over", 32'h0, crun);
    rd(`HPC_A_HF_LO, 32'h0);
    cyc(5);
    r = rnd();
    adc(r[15:0]);
    cmp_val("adc resumed", r[15:0], ares);
    $display("test self test done");
    r = rnd();
    hot <= r[7:0];
    cold <= r[15:8];
    bhot <= 8'h01;
    tref <= 1'b1;
    wr(`HPC_A_TLIM, 32'hA3);
    wr(`HPC_A_BHOT, 32'h4C);
    wr(`HPC_A_PINCFG, 32'h82);
    wr(`HPC_A_TCTRL, 32'h5);
    cyc(2);
    cmp_val("hot limit", 32'h03, hotl);
    cmp_val("cold limit", 32'h5, coldl);
    cmp_val("balance hot limit", 32'h4C, bhl);
    cmp_val("temp run", 32'h1, trun);
    cyc(40);
    rd(`HPC_A_HOTF, r & 32'h05);
    rd(`HPC_A_COLDF, (r >> 8) & 32'h05);
    rd(`HPC_A_STAT, 32'h2);
    cmp_val("balance pause", 32'h1, pause[0]);
    tref <= 1'b0;
    cyc(40);
    rd(`HPC_A_HOTF, 32'hFF);
    rd(`HPC_A_COLDF, 32'hFF);
    $display("test temp scan done");
    for (int m = 0; m < 4; m++) begin
      wr(`HPC_A_CCTRL, 32'h4 | m);
      wr(`HPC_A_TCTRL, 32'h4 | m);
      cyc(2);
      cmp_val("cell mode run", m != 0, crun);
      cmp_val("temp mode run", m != 0, trun);
      if (m == 2) begin
        cyc(2);
        cmp_val("cell single ch", 32'h3, cch);
        cmp_val("temp single ch", 32'h0, tch);
      end
    end
    cyc(80);
    cmp_val("cell sweep over", 32'h0, crun);
    cmp_val("temp sweep over", 32'h0, trun);
    wr(`HPC_A_CCTRL, 32'h5);
    wr(`HPC_A_TCTRL, 32'h5);
    shut <= 1'b1;
    cyc(3);
    cmp_val("cell shut", 32'h0, crun);
    cmp_val("temp shut", 32'h0, trun);
    $display("test modes done");
    cyc(2);
    end_of_test();
  end
endmodule
bind hpc_top hpc_chk hpc_chk_i (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .SHUTDOWN_I(SHUTDOWN_I),
  .ADC_START_I(ADC_START_I), .ADC_RUNNING_I(ADC_RUNNING_I), .ADC_RESULT_O(ADC_RESULT_O),
  .CELL_HIGH_LIMIT_O(CELL_HIGH_LIMIT_O), .CELL_RUN_O(CELL_RUN_O), .TEMP_RUN_O(TEMP_RUN_O));
